// File: egc_group_ctrl.sv
// per-group control bits and interrupt queue behind an AHB-Lite slave
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps

module egc_group_ctrl
  import egc_pkg::*;
#(
  parameter int NGROUPS = 4,
  parameter int QDEPTH  = 8
) (
  input  wire logic               i_clk,
  input  wire logic               i_nrst,
  // AHB-Lite slave
  input  wire logic               i_hsel,
  input  wire logic [31:0]        i_haddr,
  input  wire logic [1:0]         i_htrans,
  input  wire logic               i_hwrite,
  input  wire logic [2:0]         i_hsize,
  input  wire logic [31:0]        i_hwdata,
  input  wire logic               i_hready,
  output logic                    o_hreadyout,
  output logic                    o_hresp,
  output logic [31:0]             o_hrdata,
  // tone detector events, one-cycle pulses from on-chip logic
  input  wire logic [NGROUPS-1:0] i_tone_a,
  input  wire logic [NGROUPS-1:0] i_tone_b,
  // per-group controls toward the cancellers, then the interrupt output
  output logic [NGROUPS-1:0]      o_group_power_on,
  output logic [NGROUPS-1:0]      o_pcm_bypass,
  output logic [NGROUPS-1:0]      o_companded,
  output logic [NGROUPS-1:0]      o_alaw,
  output logic [NGROUPS-1:0]      o_group_init,
  output logic                    o_irq
);

  localparam int QPTR_W = $clog2(QDEPTH);
  localparam int QCNT_W = $clog2(QDEPTH + 1);
  localparam int NSRC   = 2 * NGROUPS;

  egc_bus_t                 bus_state;
  logic [11:0]              wr_idx;
  logic [EGC_CTRL_W-1:0]    ctrl [NGROUPS];
  logic [NGROUPS-1:0]       power_d;
  logic [EGC_CODE_W-1:0]    qmem [QDEPTH];
  logic [QPTR_W-1:0]        qwr_ptr;
  logic [QPTR_W-1:0]        qrd_ptr;
  logic [QCNT_W-1:0]        qcount;
  logic                     pend;
  logic [EGC_EV_W-1:0]      ev_stat;
  logic [EGC_EV_W-1:0]      ev_mask;
  logic [NSRC-1:0]          src_req;
  logic                     push;
  logic [EGC_CODE_W-1:0]    push_code;
  logic                     addr_take;
  logic [11:0]              addr_idx;
  logic                     queue_pop;
  logic                     qfull;
  logic                     overflow;

  // address phase decode
  assign addr_take = i_hsel & i_htrans[1] & i_hready;
  assign addr_idx  = i_haddr[EGC_ADDR_LSB +: 12];
  assign queue_pop = addr_take & ~i_hwrite & (addr_idx == EGC_IDX_QUEUE) & (qcount != '0);
  assign o_hresp   = 1'b0;
  assign o_hreadyout = (bus_state != EGC_BUS_WRITE); // write data taken in a wait cycle

  // bus phase tracker; a write stalls one cycle so a following read sees it
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      bus_state <= EGC_BUS_IDLE;
      wr_idx    <= 12'h000;
    end else begin
      case (bus_state)
        EGC_BUS_IDLE,
        EGC_BUS_WDONE: begin
          if (addr_take && i_hwrite) begin
            bus_state <= EGC_BUS_WRITE;
            wr_idx    <= addr_idx;
          end else begin
            bus_state <= EGC_BUS_IDLE;
          end
        end
        EGC_BUS_WRITE: bus_state <= EGC_BUS_WDONE;
        default:       bus_state <= EGC_BUS_IDLE;
      endcase
    end
  end

  // per-group control registers and their decoded outputs
  genvar g;
  generate
    for (g = 0; g < NGROUPS; g++) begin : gen_grp
      always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          ctrl[g] <= EGC_CTRL_RST;
        end else if (bus_state == EGC_BUS_WRITE &&
                     wr_idx == EGC_IDX_CTRL_BASE + 12'(g)) begin
          ctrl[g] <= i_hwdata[EGC_CTRL_W-1:0];
        end
      end
      assign o_group_power_on[g] = ctrl[g][EGC_BIT_POWER];
      assign o_pcm_bypass[g]     = ~ctrl[g][EGC_BIT_POWER];
      assign o_companded[g]      = ctrl[g][EGC_BIT_FORMAT];
      assign o_alaw[g]           = ctrl[g][EGC_BIT_LAW];
      assign o_group_init[g]     = ctrl[g][EGC_BIT_POWER] & ~power_d[g];
      // tone events pass only from powered groups with the mask clear
      assign src_req[2*g]   = i_tone_a[g] & ctrl[g][EGC_BIT_POWER]
                              & ~ctrl[g][EGC_BIT_MASK_A];
      assign src_req[2*g+1] = i_tone_b[g] & ctrl[g][EGC_BIT_POWER]
                              & ~ctrl[g][EGC_BIT_MASK_B];
    end
  endgenerate

  // previous power bits for the rising-edge init pulse
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      power_d <= '0;
    end else begin
      power_d <= o_group_power_on;
    end
  end

  // lowest-numbered requesting source wins a cycle; others are dropped
  always_comb begin
    push      = 1'b0;
    push_code = '0;
    for (int s = NSRC - 1; s >= 0; s--) begin
      if (src_req[s]) begin
        push      = 1'b1;
        push_code = EGC_CODE_W'(s);
      end
    end
  end

  assign qfull    = (qcount == QCNT_W'(QDEPTH));
  assign overflow = push & qfull & ~queue_pop;

  // interrupt queue storage
  always_ff @(posedge i_clk) begin
    if (push && (!qfull || queue_pop)) begin
      qmem[qwr_ptr] <= push_code;
    end
  end

  // queue pointers and fill count
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      qwr_ptr <= '0;
      qrd_ptr <= '0;
      qcount  <= '0;
    end else begin
      if (push && (!qfull || queue_pop)) begin
        qwr_ptr <= (qwr_ptr == QPTR_W'(QDEPTH - 1)) ? '0 : qwr_ptr + 1'b1;
      end
      if (queue_pop) begin
        qrd_ptr <= (qrd_ptr == QPTR_W'(QDEPTH - 1)) ? '0 : qrd_ptr + 1'b1;
      end
      if ((push && !qfull) && !queue_pop) begin
        qcount <= qcount + 1'b1;
      end else if (queue_pop && !push) begin
        qcount <= qcount - 1'b1;
      end
    end
  end

  // pending flag: a new entry sets it, a queue read clears it unless entries remain
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pend <= 1'b0;
    end else if (push) begin
      pend <= 1'b1;
    end else if (addr_take && !i_hwrite && addr_idx == EGC_IDX_QUEUE) begin
      pend <= (qcount > QCNT_W'(1));
    end
  end

  // sticky event status, write one to clear, set wins
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ev_stat <= EGC_EV_RST;
    end else begin
      if (bus_state == EGC_BUS_WRITE && wr_idx == EGC_IDX_IRQ_STAT) begin
        ev_stat <= (ev_stat & ~i_hwdata[EGC_EV_W-1:0]) | {overflow, push};
      end else begin
        ev_stat <= ev_stat | {overflow, push};
      end
    end
  end

  // interrupt mask register
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ev_mask <= EGC_EV_RST;
    end else if (bus_state == EGC_BUS_WRITE && wr_idx == EGC_IDX_IRQ_MASK) begin
      ev_mask <= i_hwdata[EGC_EV_W-1:0];
    end
  end

  assign o_irq = |(ev_stat & ev_mask);

  // read data captured in the address phase
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_hrdata <= 32'h00000000;
    end else if (addr_take && !i_hwrite) begin
      o_hrdata <= 32'h00000000;
      if (addr_idx == EGC_IDX_QUEUE) begin
        o_hrdata[EGC_BIT_PEND] <= pend;
        o_hrdata[EGC_CODE_W-1:0] <= (qcount != '0) ? qmem[qrd_ptr] : '0;
      end else if (addr_idx == EGC_IDX_IRQ_STAT) begin
        o_hrdata[EGC_EV_W-1:0] <= ev_stat;
      end else if (addr_idx == EGC_IDX_IRQ_MASK) begin
        o_hrdata[EGC_EV_W-1:0] <= ev_mask;
      end else begin
        for (int k = 0; k < NGROUPS; k++) begin
          if (addr_idx == EGC_IDX_CTRL_BASE + 12'(k)) begin
            o_hrdata[EGC_CTRL_W-1:0] <= ctrl[k];
          end
        end
      end
    end
  end

endmodule

// File: egc_group_ctrl_sva.sv
// checker of bus timing, control outputs and queue read format
`timescale 1ns/1ps
module egc_group_ctrl_chk
  import egc_pkg::*;
#(
  parameter int NGROUPS = 4
) (
  input wire logic               i_clk,
  input wire logic               i_nrst,
  input wire logic               i_hsel,
  input wire logic [31:0]        i_haddr,
  input wire logic [1:0]         i_htrans,
  input wire logic               i_hwrite,
  input wire logic               i_hready,
  input wire logic               o_hreadyout,
  input wire logic               o_hresp,
  input wire logic [31:0]        o_hrdata,
  input wire logic [NGROUPS-1:0] o_group_power_on,
  input wire logic [NGROUPS-1:0] o_pcm_bypass,
  input wire logic [NGROUPS-1:0] o_companded,
  input wire logic [NGROUPS-1:0] o_alaw,
  input wire logic [NGROUPS-1:0] o_group_init
);
  logic take;
  logic wr_dp;
  logic qrd_dp;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  assign take = i_hsel & i_htrans[1] & i_hready;
  // data phase flags of writes and queue reads
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_dp  <= 1'b0;
      qrd_dp <= 1'b0;
    end else begin
      wr_dp  <= take & i_hwrite;
      qrd_dp <= take & ~i_hwrite & (i_haddr[13:2] == EGC_IDX_QUEUE);
    end
  end
  property p_bypass; o_pcm_bypass == ~o_group_power_on; endproperty
  a_bypass: assert property (p_bypass) else $error("bypass not inverse of power");
  property p_init_pow; |o_group_init |-> (o_group_init & ~o_group_power_on) == '0; endproperty
  a_init_pow: assert property (p_init_pow) else $error("init while unpowered");
  property p_init_once; |o_group_init |=> (o_group_init & $past(o_group_init)) == '0; endproperty
  a_init_once: assert property (p_init_once) else $error("init longer than a cycle");
  property p_init_rise; (o_group_init & $past(o_group_power_on)) == '0; endproperty
  a_init_rise: assert property (p_init_rise) else $error("init without power rise");
  property p_ctrl_hold;
    !$stable({o_companded, o_alaw, o_group_power_on}) |-> $past(wr_dp);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("control changed without write");
  property p_rd_ready; take && !i_hwrite |=> o_hreadyout; endproperty
  a_rd_ready: assert property (p_rd_ready) else $error("read data phase stalled");
  property p_wr_wait; take && i_hwrite |=> !o_hreadyout ##1 o_hreadyout; endproperty
  a_wr_wait: assert property (p_wr_wait) else $error("write wait state wrong");
  property p_queue_fmt;
    qrd_dp |-> o_hrdata[31:8] == 24'h0 && o_hrdata[6:5] == 2'h0
      && (o_hrdata[7] || o_hrdata[4:0] == 5'h00);
  endproperty
  a_queue_fmt: assert property (p_queue_fmt) else $error("queue word malformed");
  property p_resp; o_hresp == 1'b0; endproperty
  a_resp: assert property (p_resp) else $error("response not okay");
endmodule
bind egc_group_ctrl egc_group_ctrl_chk #(.NGROUPS(NGROUPS)) i_chk (.i_clk, .i_nrst, .i_hsel,
  .i_haddr, .i_htrans, .i_hwrite, .i_hready, .o_hreadyout, .o_hresp, .o_hrdata,
  .o_group_power_on, .o_pcm_bypass, .o_companded, .o_alaw, .o_group_init);

// File: egc_group_ctrl_tb.sv
// self-checking bench of the echo group control block
`timescale 1ns/1ps
module egc_group_ctrl_tb;
  import egc_pkg::*;
  logic i_clk, i_nrst, i_hsel, i_hwrite, i_hready, o_hreadyout, o_hresp, o_irq, rdy;
  logic [31:0] i_haddr, i_hwdata, o_hrdata, rdat, rd;
  logic [1:0] i_htrans, ev, msk;
  logic [2:0] i_hsize;
  logic [3:0] i_tone_a, i_tone_b, o_group_power_on, o_pcm_bypass, o_companded, o_alaw;
  logic [3:0] o_group_init;
  logic [4:0] q[$];
  logic [4:0] ctl[4];
  int mismatches, n_tests, s;
  int inits[4], exp_inits[4];
  egc_group_ctrl i_dut (.i_clk, .i_nrst, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize,
    .i_hwdata, .i_hready, .o_hreadyout, .o_hresp, .o_hrdata, .i_tone_a, .i_tone_b,
    .o_group_power_on, .o_pcm_bypass, .o_companded, .o_alaw, .o_group_init, .o_irq);
  assign i_hready = o_hreadyout;
  initial begin
    i_clk = 0;
    forever #2.5 i_clk = ~i_clk;
  end
  // one-cycle init pulses seen per group
  always @(posedge i_clk) begin
    for (int g = 0; g < 4; g++) if (o_group_init[g]) inits[g]++;
  end
  // ready and read data as they stand at the next rising edge
  always @(negedge i_clk) begin
    rdy <= o_hreadyout;
    rdat <= o_hrdata;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [11:0] idx, input logic [31:0] wd);
    @(posedge i_clk);
    i_hsel <= 1;
    i_htrans <= 2'h2;
    i_hwrite <= w;
    i_hsize <= 3'h2;
    i_haddr <= {18'h0, idx, 2'h0};
    do @(posedge i_clk); while (rdy !== 1'b1);
    i_htrans <= 2'h0;
    i_hwdata <= wd;
    do @(posedge i_clk); while (rdy !== 1'b1);
    rd = rdat;
    i_hsel <= 0;
  endtask
  task ctrl(input int g, input logic [4:0] v);
    if (v[0] && ctl[g][0] !== 1'b1) exp_inits[g]++;
    ctl[g] = v;
    bus(1, EGC_IDX_CTRL_BASE + 12'(g), {27'h0, v});
    bus(0, EGC_IDX_CTRL_BASE + 12'(g), 0);
    chk(rd, {27'h0, v});
    chk(o_companded[g], v[EGC_BIT_FORMAT]);
    chk(o_alaw[g], v[EGC_BIT_LAW]);
    chk({o_group_power_on[g], o_pcm_bypass[g]}, {v[0], ~v[0]});
    chk(inits[g], exp_inits[g]);
  endtask
  task qread;
    bus(0, EGC_IDX_QUEUE, 0);
    chk(rd, q.size() ? {24'h0, 3'h4, q[0]} : 32'h0);
    if (q.size()) void'(q.pop_front());
  endtask
  // model: lowest code of powered, unmasked events is queued
  task tone(input logic [3:0] a, input logic [3:0] b);
    int c;
    c = -1;
    for (int g = 3; g >= 0; g--) begin
      if (ctl[g][0] && b[g] && !ctl[g][4]) c = 2 * g + 1;
      if (ctl[g][0] && a[g] && !ctl[g][3]) c = 2 * g;
    end
    if (c >= 0 && q.size() < 8) q.push_back(5'(c));
    else if (c >= 0) ev[1] = 1;
    if (c >= 0) ev[0] = 1;
    @(posedge i_clk);
    i_tone_a <= a;
    i_tone_b <= b;
    @(posedge i_clk);
    i_tone_a <= 0;
    i_tone_b <= 0;
    @(posedge i_clk);
    chk(o_irq, |(ev & msk));
  endtask
  task wrap_up;
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    wrap_up;
  end
  initial begin
    s = $urandom(32'h29E042E4);
    {i_hsel, i_hwrite, i_haddr, i_hwdata, i_htrans, i_hsize, i_tone_a, i_tone_b} = '0;
    {ev, msk, i_nrst} = '0;
    repeat (20) @(posedge i_clk);
    i_nrst <= 1;
    chk(o_pcm_bypass, 4'hF);
    qread;
    bus(1, 12'h3FF, 32'hFF);
    bus(0, 12'h3FF, 0);
    chk(rd, 0);
    repeat (3) for (int g = 0; g < 4; g++) ctrl(g, 5'($urandom));
    for (int g = 0; g < 4; g++) ctrl(g, 5'h01 | 5'($urandom & 6));
    msk = 2'h3;
    bus(1, EGC_IDX_IRQ_MASK, 3);
    tone(4'h2, 4'h1);
    qread;
    qread;
    ctrl(0, 5'h09);
    ctrl(1, 5'h11);
    ctrl(2, 5'h00);
    repeat (30) tone(4'($urandom), 4'($urandom));
    bus(0, EGC_IDX_IRQ_STAT, 0);
    chk(rd, {30'h0, ev});
    repeat (9) qread;
    bus(1, EGC_IDX_IRQ_STAT, 3);
    ev = 0;
    msk = 0;
    bus(1, EGC_IDX_IRQ_MASK, 0);
    tone(4'h8, 4'h0);
    qread;
    wrap_up;
  end
endmodule

// File: egc_pkg.sv
// register map, field layout and timing constants of the echo group control block
package egc_pkg;
  // register indices; byte address is four times the index
  localparam logic [11:0] EGC_IDX_CTRL_BASE = 12'h400; // group g at base + g
  localparam logic [11:0] EGC_IDX_QUEUE     = 12'h410;
  localparam logic [11:0] EGC_IDX_IRQ_STAT  = 12'h420;
  localparam logic [11:0] EGC_IDX_IRQ_MASK  = 12'h421;
  localparam int          EGC_ADDR_LSB      = 2;       // word aligned
  // group control fields
  localparam int EGC_BIT_POWER   = 0;
  localparam int EGC_BIT_LAW     = 1;
  localparam int EGC_BIT_FORMAT  = 2;
  localparam int EGC_BIT_MASK_A  = 3;
  localparam int EGC_BIT_MASK_B  = 4;
  localparam int EGC_CTRL_W      = 5;
  localparam logic [EGC_CTRL_W-1:0] EGC_CTRL_RST = 5'h00;
  // interrupt queue fields
  localparam int EGC_BIT_PEND    = 7;
  localparam int EGC_CODE_W      = 5;
  localparam logic [7:0] EGC_QUEUE_RST = 8'h00;
  // event status fields
  localparam int EGC_EV_PUSH     = 0;
  localparam int EGC_EV_OVFL     = 1;
  localparam int EGC_EV_W        = 2;
  localparam logic [EGC_EV_W-1:0] EGC_EV_RST = 2'h0;
  // bypass delay and init length in frames; the logic uses neither
  localparam int EGC_BYPASS_FRAMES = 2;
  localparam int EGC_INIT_FRAMES   = 2;
  // bus phase tracker
  typedef enum logic [1:0] {
    EGC_BUS_IDLE  = 2'b00,
    EGC_BUS_WRITE = 2'b01,
    EGC_BUS_WDONE = 2'b10
  } egc_bus_t;
endpackage
